// *** tb/clash_rssi_sva.sv ***
// checker: bus handshake, read data and interrupt request relations
`timescale 1ns/100ps
module clash_rssi_sva (
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic        i_chip_en,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [5:0]  i_src_event,
    input wire logic        i_tx_start,
    input wire logic        i_rx_active,
    input wire logic        i_rf_on,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_irq_req
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // a read request taken at one byte address
    sequence rd_at(a);
        i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == a;
    endsequence
    // quiet event inputs while a status read completes
    sequence quiet_ev;
        (i_src_event == 6'h00) [*2];
    endsequence
    a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack after request");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data outside ack");
    a_dat_upper: assert property (o_wb_dat[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_misalign_zero: assert property (i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack
        && i_wb_adr[1:0] != 2'h0 |=> o_wb_dat == 32'h0) else $error("misaligned read not 0");
    a_level_clear: assert property (i_tx_start && !i_rx_active && i_rf_on ##1 rd_at(8'h3C)
        ##0 !i_rx_active |=> o_wb_dat[5:0] == 6'h00) else $error("levels kept after tx");
    a_istat_release: assert property (rd_at(8'h4C) ##1 quiet_ev |=> !o_irq_req)
        else $error("request kept after status read");
    a_chip_off: assert property (!i_chip_en |=> !o_irq_req)
        else $error("request while chip disabled");
endmodule
bind collision_mask_rssi_status clash_rssi_sva sva_u (.*);

// *** tb/front_end_model.sv ***
// front end model: events, error reports and receive levels
`timescale 1ns/100ps
module front_end_model (
    input  wire logic       i_clk_sys,
    output logic [5:0]      o_sev = 6'h00,
    output logic            o_ev  = 1'b0,
    output logic [9:0]      o_pos = 10'h000,
    output logic            o_cl  = 1'b0,
    output logic            o_tx  = 1'b0,
    output logic            o_rx  = 1'b0,
    output logic [2:0]      o_la  = 3'h0,
    output logic [2:0]      o_lb  = 3'h0
);
    // one-cycle report of source events and an error position
    task automatic hit(input logic [5:0] s, input logic v, input logic [9:0] p, input logic c);
        o_sev <= s;
        o_ev <= v;
        o_pos <= p;
        o_cl <= c;
        @(posedge i_clk_sys);
        o_sev <= 6'h00;
        o_ev <= 1'b0;
        o_pos <= ~p;  // stale position no longer valid
        @(posedge i_clk_sys);
    endtask
    // start of a reader transmission
    task automatic tx();
        o_tx <= 1'b1;
        @(posedge i_clk_sys);
        o_tx <= 1'b0;
    endtask
    // reception peaking at a and b, envelope then falls
    task automatic rx(input logic [2:0] a, input logic [2:0] b);
        o_rx <= 1'b1;
        o_la <= a;
        o_lb <= b;
        repeat (3) @(posedge i_clk_sys);
        o_la <= 3'h1;  // below peak
        o_lb <= 3'h1;
        repeat (3) @(posedge i_clk_sys);
        o_rx <= 1'b0;
        o_la <= 3'h7;  // noise outside a frame
        o_lb <= 3'h7;
        repeat (2) @(posedge i_clk_sys);
    endtask
endmodule

// *** tb/tb_top.sv ***
// bench: bus tasks and register tests for the clash and level bank
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, en = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        rf_on = 1'b1, ack, irq_req, irq, ev, cl, txs, rxa;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat;
    logic [2:0]  ampl = 3'h0, la, lb;
    logic [5:0]  sev;
    logic [9:0]  pos;
    int          fails = 0, cmp_count = 0, cyc_n = 0;
    initial forever #2.5 clk = ~clk;
    collision_mask_rssi_status #(.OSC_SETTLE(16)) dut_u (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_chip_en(en), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack), .i_src_event(sev),
        .i_err_valid(ev), .i_err_pos(pos), .i_err_is_clash(cl), .i_tx_start(txs),
        .i_rx_active(rxa), .i_rf_on(rf_on), .i_primary_receive_pin(la),
        .i_secondary_receive_pin(lb), .i_rf_ampl(ampl), .i_osc_run(1'b1),
        .o_irq_req(irq_req), .o_irq(irq));
    front_end_model fe_u (.i_clk_sys(clk), .o_sev(sev), .o_ev(ev), .o_pos(pos), .o_cl(cl),
        .o_tx(txs), .o_rx(rxa), .o_la(la), .o_lb(lb));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rdat = dat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h34, 32'h3E);
        rd(8'h3C, 32'h00);
        rd(8'h35, 32'h00);
        rd(8'hFC, 32'h00);
        $display("test reset done");
        bus(1'b1, 8'h48, 32'h04);
        fe_u.hit(6'h00, 1'b1, 10'h2A5, 1'b1);
        fe_u.hit(6'h00, 1'b1, 10'h0F0, 1'b0);
        rd(8'h34, 32'hBE);
        rd(8'h38, 32'hA5);
        rd(8'h38, 32'h00);
        bus(1'b1, 8'h48, 32'h00);
        fe_u.hit(6'h00, 1'b1, 10'h15A, 1'b0);
        rd(8'h38, 32'h5A);
        bus(1'b1, 8'h34, 32'hFF);
        rd(8'h34, 32'h7F);
        en <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        rd(8'h34, 32'h3E);
        $display("test capture done");
        // enable low restarted the settle counter, let the oscillator settle again
        repeat (20) @(posedge clk);
        fe_u.tx();
        rd(8'h3C, 32'h40);
        fe_u.rx(3'h3, 3'h5);
        rd(8'h3C, 32'h6B);
        bus(1'b1, 8'h48, 32'h01);
        fe_u.tx();
        fe_u.rx(3'h3, 3'h5);
        rd(8'h3C, 32'h5D);
        fe_u.tx();
        rf_on <= 1'b0; ampl <= 3'h6;
        bus(1'b1, 8'h48, 32'h02);
        repeat (4) @(posedge clk);
        rd(8'h3C, 32'h46);
        rf_on <= 1'b1;
        $display("test level done");
        bus(1'b1, 8'h34, 32'h01);
        fe_u.hit(6'h02, 1'b0, 10'h000, 1'b0);
        chk(32'(irq_req), 32'h0);
        fe_u.hit(6'h01, 1'b0, 10'h000, 1'b0);
        chk(32'(irq_req), 32'h1);
        rd(8'h4C, 32'h03);
        repeat (2) @(posedge clk);
        chk(32'(irq_req), 32'h0);
        bus(1'b1, 8'h40, 32'h07);
        bus(1'b1, 8'h44, 32'h01);
        fe_u.hit(6'h00, 1'b1, 10'h003, 1'b0);
        chk(32'(irq), 32'h1);
        bus(1'b1, 8'h44, 32'h00);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        bus(1'b1, 8'h40, 32'h01);
        bus(1'b1, 8'h44, 32'h01);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("test interrupt done");
        final_report();
    end
endmodule

// *** verilog/clash_rssi_pkg.sv ***
// package: register map, reset values and timing for the clash/signal status bank
package clash_rssi_pkg;
    // register indices (printed offsets are not multiples of four)
    localparam logic [7:0] IDX_MASK   = 8'h0D;
    localparam logic [7:0] IDX_CLASH  = 8'h0E;
    localparam logic [7:0] IDX_LEVEL  = 8'h0F;
    localparam logic [7:0] IDX_EVENT  = 8'h10;
    localparam logic [7:0] IDX_EVMASK = 8'h11;
    localparam logic [7:0] IDX_CTRL   = 8'h12;
    localparam logic [7:0] IDX_ISTAT  = 8'h13;
    localparam int         ADDR_SHIFT = 2;
    // reset values
    localparam logic [5:0] MASK_RST   = 6'h3E;
    localparam logic [7:0] CLASH_RST  = 8'h00;
    localparam logic [2:0] EV_RST     = 3'h0;
    localparam logic [2:0] CTRL_RST   = 3'h0;
    // field positions
    localparam int         OSC_BIT    = 6;
    localparam int         CTRL_SWAP  = 0;
    localparam int         CTRL_AMPL  = 1;
    localparam int         CTRL_TYPEA = 2;
    // event bits: 0 clash captured, 1 oscillator stable, 2 level latched
    localparam int         EV_CLASH   = 0;
    localparam int         EV_OSC     = 1;
    localparam int         EV_LEVEL   = 2;
    // oscillator settle time
    localparam int         CLK_MHZ    = 200;
    localparam int         OSC_US     = 200;
    localparam int         OSC_CYC    = OSC_US * CLK_MHZ;
    // per-source status/enable word, bit 5 fifo .. bit 0 no-response
    typedef struct packed {
        logic fifo;
        logic crc;
        logic parity;
        logic framing;
        logic clash;
        logic noresp;
    } irq_src_s;
endpackage

// *** verilog/collision_mask_rssi_status.sv ***
// collision position, interrupt mask and signal level status register bank
// Contract
// R1 - mask bits 5..1 enable fifo, crc, parity, framing, collision; reset to one
// R2 - mask bit 0 enables no-response interrupt; reset to zero
// R3 - 10-bit clash index: bits 9:8 in mask reg 7:6, low byte at 0x0E
// R4 - low clash byte zero at reset or enable low, cleared after each read
// R5 - outside type A, capture holds bit position of framing/parity/CRC error
// R6 - level register bit 6 shows oscillator stable, about 200 us after start
// R7 - bits 5:3 aux level from second input, first input when swap set
// R8 - bits 2:0 main channel level, bit 2 most significant
// R9 - levels follow envelope and hold the peak after packet end; the code only tracks rises, keeping the running peak
// R10 - latched levels cleared when next transmission starts
// R11 - each level is a 3-bit code, seven steps of 4 dB
// R12 - levels valid from reception start until next transmission
// R13 - with field off, register shows measured RF amplitude on request
// R14 - reading interrupt status clears it and releases the request line
// R15 - masked source does not drive request line, status still recorded
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
module collision_mask_rssi_status #(
    parameter int OSC_SETTLE = clash_rssi_pkg::OSC_CYC
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_chip_en,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic [5:0]  i_src_event,
    input  wire logic        i_err_valid,
    input  wire logic [9:0]  i_err_pos,
    input  wire logic        i_err_is_clash,
    input  wire logic        i_tx_start,
    input  wire logic        i_rx_active,
    input  wire logic        i_rf_on,
    input  wire logic [2:0]  i_primary_receive_pin,
    input  wire logic [2:0]  i_secondary_receive_pin,
    input  wire logic [2:0]  i_rf_ampl,
    input  wire logic        i_osc_run,
    output logic             o_irq_req,
    output logic             o_irq
);
    // state
    clash_rssi_pkg::irq_src_s mask_q, mask_d, istat_q, istat_d;
    logic [9:0]  clash_q, clash_d;
    logic [2:0]  main_q, main_d, aux_q, aux_d;
    logic        osc_ok_q;
    logic [15:0] osc_cnt_q;
    logic [2:0]  ev_q, ev_d, evmask_q, evmask_d, ctrl_q, ctrl_d;
    logic        irq_req_q, irq_q;

    // bus decode
    wire        req      = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire        in_range = i_wb_adr[1:0] == 2'h0;
    wire [5:0]  idx      = i_wb_adr[7:clash_rssi_pkg::ADDR_SHIFT];
    wire        wr       = req & i_wb_we & i_wb_sel[0] & in_range;
    wire        rd       = req & ~i_wb_we & in_range;
    wire        hit_mask = idx == clash_rssi_pkg::IDX_MASK[5:0];
    wire        hit_cl   = idx == clash_rssi_pkg::IDX_CLASH[5:0];
    wire        hit_lvl  = idx == clash_rssi_pkg::IDX_LEVEL[5:0];
    wire        hit_ev   = idx == clash_rssi_pkg::IDX_EVENT[5:0];
    wire        hit_evm  = idx == clash_rssi_pkg::IDX_EVMASK[5:0];
    wire        hit_ctl  = idx == clash_rssi_pkg::IDX_CTRL[5:0];
    wire        hit_ist  = idx == clash_rssi_pkg::IDX_ISTAT[5:0];
    wire [7:0]  wdat     = i_wb_dat[7:0];
    wire        clr_en   = ~i_chip_en;
    wire        swap     = ctrl_q[clash_rssi_pkg::CTRL_SWAP];
    wire        ampl_req = ctrl_q[clash_rssi_pkg::CTRL_AMPL];
    wire        type_a   = ctrl_q[clash_rssi_pkg::CTRL_TYPEA];

    // capture only collisions under type A, only errors otherwise
    wire        cap      = i_err_valid & (type_a == i_err_is_clash); // R5

    // level sources, channel swap and field-off amplitude path
    wire [2:0]  main_src = swap ? i_secondary_receive_pin : i_primary_receive_pin;
    wire [2:0]  aux_src  = swap ? i_primary_receive_pin : i_secondary_receive_pin; // R7
    wire        ampl_mod = ~i_rf_on & ampl_req; // R13
    wire        track    = i_rx_active | ampl_mod; // R12

    // peak hold per channel, 3-bit codes of 4 dB steps
    always_comb begin
        main_d = main_q;
        aux_d  = aux_q;
        if (i_tx_start) begin
            main_d = 3'h0; // R10
            aux_d  = 3'h0; // R10
        end else if (ampl_mod) begin
            main_d = i_rf_ampl; // R13
            aux_d  = 3'h0;
        end else if (track) begin
            if (main_src > main_q) main_d = main_src; // R9 R11
            if (aux_src > aux_q) aux_d = aux_src; // R9
        end
    end

    // clash index: event capture wins over clear on read
    always_comb begin
        clash_d = clash_q;
        if (rd & hit_cl) clash_d[7:0] = clash_rssi_pkg::CLASH_RST; // R4
        if (cap) clash_d = i_err_pos; // R3
    end

    // mask register writes, bits 7:6 are read-only clash bits
    always_comb begin
        mask_d = mask_q;
        if (wr & hit_mask) mask_d = wdat[5:0]; // R1 R2
    end

    // interrupt status: set wins, read clears
    always_comb begin
        istat_d = istat_q;
        if (rd & hit_ist) istat_d = '0; // R14
        istat_d = istat_d | i_src_event; // R15
    end

    // own event bits, write one to clear, set wins
    wire [2:0] ev_set = {(main_d != main_q) | (aux_d != aux_q),
                         (osc_cnt_q == 16'(OSC_SETTLE - 1)) & ~osc_ok_q,
                         cap};
    always_comb begin
        ev_d     = ev_q;
        evmask_d = evmask_q;
        ctrl_d   = ctrl_q;
        if (wr & hit_ev) ev_d = ev_q & ~wdat[2:0];
        ev_d = ev_d | ev_set;
        if (wr & hit_evm) evmask_d = wdat[2:0];
        if (wr & hit_ctl) ctrl_d = wdat[2:0];
    end

    // read data mux
    wire [7:0] rdat = hit_mask ? {clash_q[9:8], mask_q} :
                      hit_cl   ? clash_q[7:0] :
                      hit_lvl  ? {1'b0, osc_ok_q, aux_q, main_q} : // R6 R7 R8
                      hit_ev   ? {5'h00, ev_q} :
                      hit_evm  ? {5'h00, evmask_q} :
                      hit_ctl  ? {5'h00, ctrl_q} :
                      hit_ist  ? {2'h0, istat_q} : 8'h00;

    // request line only from enabled sources
    wire irq_req_d = |(istat_d & mask_d); // R15 R14
    wire irq_d     = |(ev_d & evmask_d);

    // bus answer, one cycle after request
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= {24'h00_0000, (req & ~i_wb_we & in_range) ? rdat : 8'h00};
        end
    end

    // oscillator settle counter
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_cnt_q <= 16'h0000;
            osc_ok_q  <= 1'b0;
        end else if (!i_osc_run | clr_en) begin
            osc_cnt_q <= 16'h0000;
            osc_ok_q  <= 1'b0;
        end else if (!osc_ok_q) begin
            osc_cnt_q <= osc_cnt_q + 16'h0001;
            osc_ok_q  <= osc_cnt_q == 16'(OSC_SETTLE - 1); // R6
        end
    end

    // register state, chip enable low resets all but event, event mask, control and irq
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_q    <= clash_rssi_pkg::MASK_RST; // R1 R2
            clash_q   <= 10'h000; // R4
            istat_q   <= '0;
            main_q    <= 3'h0;
            aux_q     <= 3'h0;
            ev_q      <= clash_rssi_pkg::EV_RST;
            evmask_q  <= clash_rssi_pkg::EV_RST;
            ctrl_q    <= clash_rssi_pkg::CTRL_RST;
            irq_req_q <= 1'b0;
            irq_q     <= 1'b0;
        end else if (clr_en) begin
            mask_q    <= clash_rssi_pkg::MASK_RST;
            clash_q   <= 10'h000; // R4
            istat_q   <= '0;
            main_q    <= 3'h0;
            aux_q     <= 3'h0;
            ev_q      <= ev_q;
            evmask_q  <= evmask_q;
            ctrl_q    <= ctrl_q;
            irq_req_q <= 1'b0;
            irq_q     <= irq_q;
        end else begin
            mask_q    <= mask_d;
            clash_q   <= clash_d;
            istat_q   <= istat_d;
            main_q    <= main_d;
            aux_q     <= aux_d;
            ev_q      <= ev_d;
            evmask_q  <= evmask_d;
            ctrl_q    <= ctrl_d;
            irq_req_q <= irq_req_d;
            irq_q     <= irq_d;
        end
    end

    assign o_irq_req = irq_req_q;
    assign o_irq     = irq_q;
endmodule
